// *** core/supply_regs_consts.svh ***
// register offsets, reset values and field positions of the supply status and enable bank
`ifndef SUPPLY_REGS_CONSTS_SVH
`define SUPPLY_REGS_CONSTS_SVH

`define ADDR_REVISION 8'h00
`define ADDR_FAULT_FLAGS 8'h01
`define ADDR_FAULT_HIDE 8'h02
`define ADDR_SUPPLY_ENABLE 8'h03

`define RESET_FAULT_HIDE 8'hC0
`define RESET_SUPPLY_ENABLE 8'hFF
`define UNMAPPED_READ 8'hFF

`define BIT_POWER_FAIL 7
`define BIT_LOW_BATTERY 6
`define BIT_BUCK1 5
`define BIT_BUCK2 4
`define BIT_BUCK3 3
`define BIT_LINREG2 2
`define BIT_LINREG1 1
`define RAIL_LSB 1
`define RAIL_MSB 5
`define RAIL_MASK 8'h3E

`endif

// *** core/supply_regs_pkg.sv ***
// types shared by the supply status and enable register bank
package supply_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] rail_vec_t;
  typedef enum logic [4:0] {
    SEL_REVISION = 5'h01,
    SEL_FAULT = 5'h02,
    SEL_HIDE = 5'h04,
    SEL_ENABLE = 5'h08,
    SEL_NONE = 5'h10
  } reg_sel_t;
endpackage

// *** core/supply_status_enable_regs.sv ***
// supply fault status, fault hide and supply enable registers with interrupt pin drive
`timescale 1ns/1ps
`include "supply_regs_consts.svh"

// What this block does
// - Status bits 7 and 6 read 1 while the power-fail or low-battery sense is below threshold.
// - Status bits 5 to 1 read 1 while buck 1, 2, 3, linear reg 2 or 1 is below target.
// - A rail's status bit is forced to 0 while that rail is disabled.
// - The buck 3 status bit is held at 0 during a core-voltage ramp.
// - The fault status register sits at 01h and ignores writes.
// - The revision register sits at 00h, holds a fixed byte and is read-only.
// - A hide bit of 1 keeps the matching status bit off the interrupt pin; 0 lets it through.
// - The hide register sits at 02h, is read/write and loads C0h on lockout.
// - The supply enable register sits at 03h, is read/write and loads FFh on lockout.
// - A supply turns on only when its enable bit and its enable pin are both 1.
// - While an enable pin is low its enable bit is forced back to 1.
// - Enable bits 5 to 1 control buck 1, 2, 3, linear reg 2 and 1, and are host writable.
// - The shared linear-regulator pin going low restores both linear enable bits.
// - Status bits active when the status register is read are blocked from the interrupt.
// - The interrupt pin is pulled low by any status bit, rail or sense, that is neither hidden nor read-blocked.
// - A read from an unimplemented address returns FFh.
module supply_status_enable_regs #(
  parameter logic [7:0] REVISION_ID = 8'hA5 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // lockout loads register defaults while high
  input wire logic supply_lockout,
  // register port from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // comparator results, 1 = below threshold / below target
  input wire logic power_fail_sense,
  input wire logic low_battery_sense,
  input wire logic [4:0] rail_below_target,
  input wire logic core_voltage_ramp,
  // external enable pins
  input wire logic buck1_enable_pin,
  input wire logic buck2_enable_pin,
  input wire logic buck3_enable_pin,
  input wire logic linear_regs_enable_pin,
  // supply turn-on, bit 4 buck1 .. bit 0 linear reg one
  output logic [4:0] supply_on,
  // open-drain interrupt pin, low means an unhidden, unblocked status bit is set
  output logic int_n_out,
  output logic int_n_oe
);

  function automatic supply_regs_pkg::reg_sel_t decode(input logic [7:0] a);
    if (a == `ADDR_REVISION) begin
      decode = supply_regs_pkg::SEL_REVISION;
    end else if (a == `ADDR_FAULT_FLAGS) begin
      decode = supply_regs_pkg::SEL_FAULT;
    end else if (a == `ADDR_FAULT_HIDE) begin
      decode = supply_regs_pkg::SEL_HIDE;
    end else if (a == `ADDR_SUPPLY_ENABLE) begin
      decode = supply_regs_pkg::SEL_ENABLE;
    end else begin
      decode = supply_regs_pkg::SEL_NONE;
    end
  endfunction

  // a write strobe aimed at one particular register
  function automatic logic write_hit(input logic wr,
                                     input supply_regs_pkg::reg_sel_t sel,
                                     input supply_regs_pkg::reg_sel_t target);
    write_hit = wr && (sel == target);
  endfunction

  // a read strobe aimed at one particular register
  function automatic logic read_hit(input logic rd,
                                    input supply_regs_pkg::reg_sel_t sel,
                                    input supply_regs_pkg::reg_sel_t target);
    read_hit = rd && (sel == target);
  endfunction

  supply_regs_pkg::reg_byte_t fault_hide_bits;
  supply_regs_pkg::reg_byte_t supply_enable_reg;
  supply_regs_pkg::reg_byte_t read_blocked;
  supply_regs_pkg::reg_byte_t next_fault_hide_bits;
  supply_regs_pkg::reg_byte_t next_supply_enable_reg;
  supply_regs_pkg::reg_byte_t next_read_blocked;
  supply_regs_pkg::reg_byte_t next_reg_rdata;
  supply_regs_pkg::reg_byte_t supply_fault_flags;
  supply_regs_pkg::rail_vec_t pin_vec;
  supply_regs_pkg::rail_vec_t next_supply_on;
  supply_regs_pkg::reg_sel_t wsel;
  supply_regs_pkg::reg_sel_t rsel;
  logic next_int_n_oe;
  supply_regs_pkg::rail_vec_t restore_req;

  // rail order matches status and enable bits 5..1
  assign pin_vec = {buck1_enable_pin, buck2_enable_pin, buck3_enable_pin,
                    linear_regs_enable_pin, linear_regs_enable_pin};
  assign wsel = decode(reg_addr);
  assign rsel = decode(reg_addr);
  assign int_n_out = 1'b0;

  // one restore request per rail; both linear bits follow the shared pin
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gen_restore
      assign restore_req[g] = ~pin_vec[g];
    end
  endgenerate

  // status is live, so a read shows the comparators of this very cycle
  always_comb begin
    supply_fault_flags = 8'h00;
    supply_fault_flags[`BIT_POWER_FAIL] = power_fail_sense;
    supply_fault_flags[`BIT_LOW_BATTERY] = low_battery_sense;
    supply_fault_flags[`RAIL_MSB:`RAIL_LSB] = rail_below_target & supply_on;
    if (core_voltage_ramp) begin
      supply_fault_flags[`BIT_BUCK3] = 1'b0;
    end
  end

  // hide register
  always_comb begin
    next_fault_hide_bits = fault_hide_bits;
    if (supply_lockout) begin
      next_fault_hide_bits = `RESET_FAULT_HIDE;
    end else if (write_hit(reg_wr, wsel, supply_regs_pkg::SEL_HIDE)) begin
      next_fault_hide_bits = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_hide_bits <= `RESET_FAULT_HIDE;
    end else begin
      fault_hide_bits <= next_fault_hide_bits;
    end
  end

  // supply enable register
  // writes to the revision and status addresses fall through untouched
  always_comb begin
    next_supply_enable_reg = supply_enable_reg;
    if (write_hit(reg_wr, wsel, supply_regs_pkg::SEL_ENABLE)) begin
      next_supply_enable_reg = (reg_wdata & `RAIL_MASK) | ~`RAIL_MASK;
    end
    // restore follows the write so a low pin wins over a host 0
    for (int i = 0; i < 5; i++) begin
      if (restore_req[i]) begin
        next_supply_enable_reg[i + `RAIL_LSB] = 1'b1;
      end
    end
    if (supply_lockout) begin
      next_supply_enable_reg = `RESET_SUPPLY_ENABLE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_enable_reg <= `RESET_SUPPLY_ENABLE;
    end else begin
      supply_enable_reg <= next_supply_enable_reg;
    end
  end

  // read blocks: set by a status read, which wins over the clear
  always_comb begin
    // a block lasts only while its fault lasts, so a later fault pulls the pin low again
    next_read_blocked = read_blocked & supply_fault_flags;
    if (read_hit(reg_rd, rsel, supply_regs_pkg::SEL_FAULT)) begin
      next_read_blocked = next_read_blocked | supply_fault_flags;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_blocked <= 8'h00;
    end else begin
      read_blocked <= next_read_blocked;
    end
  end

  // read data holds its last value between reads
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      if (rsel == supply_regs_pkg::SEL_REVISION) begin
        next_reg_rdata = REVISION_ID;
      end else if (rsel == supply_regs_pkg::SEL_FAULT) begin
        next_reg_rdata = supply_fault_flags;
      end else if (rsel == supply_regs_pkg::SEL_HIDE) begin
        next_reg_rdata = fault_hide_bits;
      end else if (rsel == supply_regs_pkg::SEL_ENABLE) begin
        next_reg_rdata = supply_enable_reg;
      end else begin
        next_reg_rdata = `UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // rail turn-on and interrupt drive, both from next values so they track writes at once
  always_comb begin
    next_supply_on = next_supply_enable_reg[`RAIL_MSB:`RAIL_LSB] & pin_vec;
    // bit 0 of status is always 0, so it never pulls the pin
    next_int_n_oe = |(supply_fault_flags & ~next_fault_hide_bits & ~next_read_blocked);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_on <= 5'h00;
      int_n_oe <= 1'b0;
    end else begin
      supply_on <= next_supply_on;
      int_n_oe <= next_int_n_oe;
    end
  end

endmodule

// *** tb/host_model.sv ***
// host side model driving the register port of the bank
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic [7:0] reg_addr, reg_wdata,
  output logic reg_wr, reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // strobes last one cycle, so accesses never overlap
  task automatic wr(input logic [7:0] a, v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    v = reg_rdata;
  endtask
endmodule

// *** tb/supply_regs_props.sv ***
// assertion checker for the supply status and enable register bank
`timescale 1ns/1ps
module supply_regs_props #(parameter logic [7:0] REVISION_ID = 8'hA5) (
  input wire logic clk, nrst, reg_rd, reg_wr,
  input wire logic [7:0] reg_addr, reg_rdata,
  input wire logic power_fail_sense, core_voltage_ramp, int_n_oe,
  input wire logic buck1_enable_pin, linear_regs_enable_pin,
  input wire logic [4:0] supply_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence stat_rd; reg_rd && reg_addr == 8'h01; endsequence
  sequence buck_back; !buck1_enable_pin ##1 (buck1_enable_pin && !reg_wr); endsequence
  sequence lin_back; !linear_regs_enable_pin ##1 (linear_regs_enable_pin && !reg_wr); endsequence
  rail_off_a: assert property (!buck1_enable_pin |=> !supply_on[4])
    else $error("buck1 on with pin low");
  buck_restore_a: assert property (buck_back |=> supply_on[4])
    else $error("buck1 not restored");
  lin_restore_a: assert property (lin_back |=> supply_on[1:0] == 2'b11)
    else $error("linear pair not restored");
  unmapped_ff_a: assert property (reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'hFF)
    else $error("unmapped read not FF");
  revision_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == REVISION_ID)
    else $error("revision wrong");
  sense_bit_a: assert property (stat_rd |=> reg_rdata[7] == $past(power_fail_sense))
    else $error("power fail bit wrong");
  ramp_hide_a: assert property (stat_rd ##0 core_voltage_ramp |=> !reg_rdata[3])
    else $error("buck3 flag during ramp");
  read_block_a: assert property (stat_rd |=> !int_n_oe)
    else $error("interrupt after status read");
endmodule
bind supply_status_enable_regs supply_regs_props #(.REVISION_ID(REVISION_ID)) p(.*);

// *** tb/testbench.sv ***
// self-checking bench for the supply status and enable register bank
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, supply_lockout, power_fail_sense, low_battery_sense, core_voltage_ramp;
  logic buck1_enable_pin, buck2_enable_pin, buck3_enable_pin, linear_regs_enable_pin;
  logic [4:0] rail_below_target, supply_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, int_n_out, int_n_oe;
  int n_mismatch = 0;
  int checks = 0;
  host_model host(.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  supply_status_enable_regs DUT(.*);
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, exp);
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    {nrst, supply_lockout, power_fail_sense, low_battery_sense, core_voltage_ramp} = '0;
    {buck1_enable_pin, buck2_enable_pin, buck3_enable_pin, linear_regs_enable_pin} = '1;
    rail_below_target = 5'h1F;
    repeat (3) @(negedge clk);
    nrst = 1;
    rc(8'h00, 8'hA5);
    rc(8'h07, 8'hFF);
    rc(8'h02, 8'hC0);
    rc(8'h03, 8'hFF);
    $display("test defaults done");
    host.wr(8'h01, 8'h00);
    host.wr(8'h03, 8'h00);
    rc(8'h03, 8'hC1);
    chk({3'h0, supply_on}, 8'h00);
    power_fail_sense = 1;
    low_battery_sense = 1;
    rc(8'h01, 8'hC0);
    buck1_enable_pin = 0;
    @(negedge clk);
    buck1_enable_pin = 1;
    linear_regs_enable_pin = 0;
    @(negedge clk);
    linear_regs_enable_pin = 1;
    rc(8'h03, 8'hE7);
    chk({3'h0, supply_on}, 8'h13);
    rc(8'h01, 8'hE6);
    host.wr(8'h03, 8'hFF);
    core_voltage_ramp = 1;
    rc(8'h01, 8'hF6);
    core_voltage_ramp = 0;
    rc(8'h01, 8'hFE);
    chk({7'h0, int_n_oe}, 8'h00);
    $display("test enables and status done");
    host.wr(8'h02, 8'h00);
    low_battery_sense = 0;
    @(negedge clk);
    low_battery_sense = 1;
    repeat (2) @(negedge clk);
    chk({7'h0, int_n_oe}, 8'h01);
    host.wr(8'h02, 8'h40);
    chk({7'h0, int_n_oe}, 8'h00);
    chk({7'h0, int_n_out}, 8'h00);
    host.wr(8'h03, 8'h20);
    supply_lockout = 1;
    @(negedge clk);
    supply_lockout = 0;
    rc(8'h02, 8'hC0);
    rc(8'h03, 8'hFF);
    $display("test interrupt and lockout done");
    finish_test;
  end
endmodule
